// File: rtl/counter_array_cfg.svh
`ifndef COUNTER_ARRAY_CFG_SVH
`define COUNTER_ARRAY_CFG_SVH
// special function register addresses
`define CTRL_REG_ADDR 8'hd8
`define MODE_REG_ADDR 8'hd9
// control register bit positions
`define CTRL_OVF_BIT 7
`define CTRL_RUN_BIT 6
`define CTRL_RSVD_BIT 5
`define CTRL_MOD_MSB 4
// mode register bit positions
`define MODE_IDLE_STOP_BIT 7
`define MODE_WDOG_BIT 6
`define MODE_OVF_IRQ_BIT 0
// reset values
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define COUNT_RESET 16'h0000
`endif

// File: rtl/counter_array_pkg.sv
package counter_array_pkg;
  // one register access from the processor
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_RUNNING = 2'b01,
    ST_IDLE_HELD = 2'b10
  } run_state_t;
endpackage : counter_array_pkg

// File: rtl/counter_tick.sv
`timescale 1ns/100ps
`default_nettype none
// free-running counter that advances only while enabled
module counter_tick #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // control
  input wire logic advance_in,
  // result
  output logic [WIDTH-1:0] count_out,
  output logic wrap_out
);
  logic [WIDTH-1:0] count_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
    end else if (advance_in) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign count_out = count_r;
  assign wrap_out = advance_in && (count_r == {WIDTH{1'b1}});
endmodule : counter_tick
`default_nettype wire

// File: rtl/counter_array_control.sv
// How it works
// - with idle-stop set, counting halts while processor idles; otherwise continues
// - a mode bit enables watchdog behaviour of compare module 4
// - interrupt requested when overflow flag and overflow enable are both set
// - counter runs only while run bit is 1, software sets and clears it
// - rollover or software 1 sets overflow flag; only software 0 clears it
// - five module flags at bits 0..4 set by module match or capture
// - hardware never clears module flags; software writes 0 to clear
// - bit 5 reserved; reads back zero here, writes ignored
// - control register resets to zero in all defined bits
`timescale 1ns/100ps
`default_nettype none
`include "counter_array_cfg.svh"
module counter_array_control
  import counter_array_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int N_MOD = 5
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // processor special function register port
  input wire counter_array_pkg::sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  // processor state
  input wire logic cpu_idle_in,
  // compare/capture module events, one-cycle pulses
  input wire logic [N_MOD-1:0] module_event_in,
  // status to the rest of the array
  output logic [COUNT_W-1:0] count_out,
  output logic count_advance_out,
  output logic module4_watchdog_en_out,
  output logic overflow_irq_out
);
  import counter_array_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic counter_overflow_flag_r;
  logic counter_run_bit_r;
  logic [N_MOD-1:0] module_event_flag_r;
  logic idle_stop_bit_r;
  logic module4_watchdog_en_r;
  logic overflow_irq_en_r;
  logic [7:0] sfr_rdata_r;
  run_state_t state_r;
  logic wrap;
  logic ctrl_wr;
  logic mode_wr;

  function automatic logic hit(input sfr_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  assign ctrl_wr = hit(sfr_req_in, `CTRL_REG_ADDR);
  assign mode_wr = hit(sfr_req_in, `MODE_REG_ADDR);

  // ****************************************
  // run control
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      counter_run_bit_r <= 1'b0;
    end else if (ctrl_wr) begin
      counter_run_bit_r <= sfr_req_in.wdata[`CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_r <= ST_STOPPED;
    end else begin
      case (state_r)
        ST_STOPPED: begin
          if (counter_run_bit_r) begin
            state_r <= (idle_stop_bit_r && cpu_idle_in) ? ST_IDLE_HELD : ST_RUNNING;
          end
        end
        ST_RUNNING, ST_IDLE_HELD: begin
          if (!counter_run_bit_r) begin
            state_r <= ST_STOPPED;
          end else begin
            state_r <= (idle_stop_bit_r && cpu_idle_in) ? ST_IDLE_HELD : ST_RUNNING;
          end
        end
        default: begin
          state_r <= ST_STOPPED;
        end
      endcase
    end
  end

  // combinational gate so a stop takes effect the cycle it is seen
  assign count_advance_out = counter_run_bit_r
                             && !(idle_stop_bit_r && cpu_idle_in);

  counter_tick #(
    .WIDTH(COUNT_W)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .advance_in(count_advance_out),
    .count_out(count_out),
    .wrap_out(wrap)
  );

  // ****************************************
  // flags: hardware set wins over software clear
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      counter_overflow_flag_r <= 1'b0;
    end else if (wrap) begin
      counter_overflow_flag_r <= 1'b1;
    end else if (ctrl_wr) begin
      counter_overflow_flag_r <= sfr_req_in.wdata[`CTRL_OVF_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_MOD; g++) begin : g_mod_flag
      always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
          module_event_flag_r[g] <= 1'b0;
        end else if (module_event_in[g]) begin
          module_event_flag_r[g] <= 1'b1;
        end else if (ctrl_wr && !sfr_req_in.wdata[g]) begin
          module_event_flag_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // mode register
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      idle_stop_bit_r <= 1'b0;
      module4_watchdog_en_r <= 1'b0;
      overflow_irq_en_r <= 1'b0;
    end else if (mode_wr) begin
      idle_stop_bit_r <= sfr_req_in.wdata[`MODE_IDLE_STOP_BIT];
      module4_watchdog_en_r <= sfr_req_in.wdata[`MODE_WDOG_BIT];
      overflow_irq_en_r <= sfr_req_in.wdata[`MODE_OVF_IRQ_BIT];
    end
  end

  assign module4_watchdog_en_out = module4_watchdog_en_r;
  assign overflow_irq_out = counter_overflow_flag_r && overflow_irq_en_r;

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_req_in.rd && sfr_req_in.addr == `CTRL_REG_ADDR) begin
      sfr_rdata_r <= {counter_overflow_flag_r, counter_run_bit_r, 1'b0,
                      module_event_flag_r};
    end else if (sfr_req_in.rd && sfr_req_in.addr == `MODE_REG_ADDR) begin
      sfr_rdata_r <= {idle_stop_bit_r, module4_watchdog_en_r, 5'h00, overflow_irq_en_r};
    end else if (sfr_req_in.rd) begin
      sfr_rdata_r <= 8'h00;
    end
  end
  assign sfr_rdata_out = sfr_rdata_r;

  // ****************************************
  // checks
  // ****************************************
  property p_idle_hold;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (idle_stop_bit_r && cpu_idle_in) |=> (count_out == $past(count_out));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counter moved in idle stop");

  property p_wdog;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      mode_wr |=> (module4_watchdog_en_out == $past(sfr_req_in.wdata[`MODE_WDOG_BIT]));
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog enable not taken");

  // the request may only rise after a wrap, a software set or an enable write
  property p_irq;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(overflow_irq_out) |-> $past(wrap
        || (ctrl_wr && sfr_req_in.wdata[`CTRL_OVF_BIT])
        || (mode_wr && sfr_req_in.wdata[`MODE_OVF_IRQ_BIT]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_run;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (counter_run_bit_r && !cpu_idle_in) |=> (count_out == $past(count_out) + 1'b1);
  endproperty
  a_run: assert property (p_run) else $error("counter did not advance");

  property p_ovf_set;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      wrap |=> counter_overflow_flag_r;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

  property p_mod_set;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      module_event_in[4] |=> module_event_flag_r[4];
  endproperty
  a_mod_set: assert property (p_mod_set) else $error("module flag not set");

  property p_mod_keep;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (module_event_flag_r[0] && !ctrl_wr) |=> module_event_flag_r[0];
  endproperty
  a_mod_keep: assert property (p_mod_keep) else $error("module flag lost");

  property p_rsvd;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      ##1 !sfr_rdata_out[`CTRL_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");

  property p_stop;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !counter_run_bit_r |-> !wrap ##1 (count_out == $past(count_out));
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");

  property p_held;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (counter_run_bit_r && idle_stop_bit_r && cpu_idle_in) |=> (state_r == ST_IDLE_HELD);
  endproperty
  a_held: assert property (p_held) else $error("idle hold state not entered");
endmodule : counter_array_control
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import counter_array_pkg::*;
  // ****************************************
  // signals and design
  // ****************************************
  // narrow counter so that a wrap is reached in a few cycles
  localparam int CW = 4;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  sfr_req_t sfr_req_in = '0;
  logic cpu_idle_in = 1'b0;
  logic [4:0] module_event_in = 5'h00;
  logic [7:0] sfr_rdata_out;
  logic [CW-1:0] count_out;
  logic count_advance_out, module4_watchdog_en_out, overflow_irq_out;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] rv;
  logic [4:0] flags, ev, w;
  logic [CW-1:0] c0;
  int k;
  counter_array_control #(.COUNT_W(CW), .N_MOD(5)) DUT (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sfr_req_in(sfr_req_in),
    .sfr_rdata_out(sfr_rdata_out), .cpu_idle_in(cpu_idle_in),
    .module_event_in(module_event_in), .count_out(count_out),
    .count_advance_out(count_advance_out),
    .module4_watchdog_en_out(module4_watchdog_en_out),
    .overflow_irq_out(overflow_irq_out));
  always #2.5 clk_sys_in = ~clk_sys_in;
  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop;
    $display("counts: checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // a hang counts as a mismatch; the run needs well under 2000 cycles
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick
  function automatic logic [7:0] ctrl_exp(input logic ovf, input logic run, input logic [4:0] f);
    ctrl_exp = {ovf, run, 1'b0, f};
  endfunction : ctrl_exp
  // an idle edge first, so back-to-back calls never re-raise a strobe in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    sfr_req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    sfr_req_in.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    sfr_req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    sfr_req_in.rd = 1'b0;
    d = sfr_rdata_out;
  endtask : rd
  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(96289));
    tick(4);
    rst_n_in = 1'b1;
    rd(8'hd8, rv);
    chk("ctrl_reset", rv & 8'hdf, 8'h00);
    rd(8'hd9, rv);
    chk("mode_reset", rv, 8'h00);
    wr(8'hd8, 8'h80);
    rd(8'hd8, rv);
    chk("ovf_sw_set", rv & 8'hdf, 8'h80);
    wr(8'hd8, 8'h00);
    rd(8'hd8, rv);
    chk("ovf_sw_clr", rv & 8'hdf, 8'h00);
    $display("test reset_and_ovf_sw done");
    wr(8'hd9, 8'h01);
    chk("irq_idle", overflow_irq_out, 1'b0);
    wr(8'hd8, 8'h40);
    chk("adv_run", count_advance_out, 1'b1);
    c0 = count_out;
    k = 1 + ($urandom % 12);
    tick(k);
    chk("count_run", count_out, CW'(c0 + k[CW-1:0]));
    tick(20);
    chk("irq_set", overflow_irq_out, 1'b1);
    wr(8'hd8, 8'h80);
    chk("adv_stop", count_advance_out, 1'b0);
    c0 = count_out;
    tick(20);
    chk("count_hold", count_out, c0);
    rd(8'hd8, rv);
    chk("ovf_kept", rv & 8'hdf, 8'h80);
    wr(8'hd9, 8'h00);
    chk("irq_masked", overflow_irq_out, 1'b0);
    wr(8'hd8, 8'h00);
    rd(8'hd8, rv);
    chk("ovf_clr", rv & 8'hdf, 8'h00);
    $display("test run_and_overflow done");
    wr(8'hd9, 8'h80);
    wr(8'hd8, 8'h40);
    cpu_idle_in = 1'b1;
    #1;
    chk("adv_idle_stop", count_advance_out, 1'b0);
    c0 = count_out;
    tick(5);
    chk("count_idle_stop", count_out, c0);
    wr(8'hd9, 8'h40);
    chk("adv_idle_run", count_advance_out, 1'b1);
    chk("wdog_on", module4_watchdog_en_out, 1'b1);
    wr(8'hd9, 8'h00);
    chk("wdog_off", module4_watchdog_en_out, 1'b0);
    cpu_idle_in = 1'b0;
    wr(8'hd8, 8'h00);
    $display("test idle_and_watchdog done");
    flags = 5'h00;
    for (int i = 0; i < 24; i++) begin
      ev = 5'($urandom);
      module_event_in = ev;
      tick(1);
      module_event_in = 5'h00;
      flags = flags | ev;
      rd(8'hd8, rv);
      chk("flags_set", rv & 8'h1f, {3'b000, flags});
      tick(2);
      rd(8'hd8, rv);
      chk("flags_kept", rv & 8'h1f, {3'b000, flags});
      w = (i % 4 == 3) ? 5'h00 : 5'($urandom);
      wr(8'hd8, {3'b000, w});
      flags = flags & w;
      rd(8'hd8, rv);
      chk("flags_wr", rv & 8'h1f, {3'b000, flags});
    end
    $display("test module_flags done");
    wr(8'hd8, 8'h9f);
    wr(8'hd7, 8'hff);
    rd(8'hd8, rv);
    chk("unmapped_wr", rv & 8'hdf, ctrl_exp(1'b1, 1'b0, flags));
    rv = 8'($urandom);
    if (rv == 8'hd8 || rv == 8'hd9) rv = 8'h00;
    rd(rv, rv);
    chk("unmapped_rd", rv, 8'h00);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
